// ---- core/frs_hiccup_timer.sv ----
// counts the restart delay; cleared whenever it is not running
module frs_hiccup_timer #(
	parameter int unsigned CYCLES = 5000000
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic run,
	output logic      done
);

	localparam int unsigned CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_reg;

	// restart from zero whenever run drops, so a returning fault restarts the wait
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			count_reg <= '0;
			done      <= 1'b0;
		end else if (!done) begin
			count_reg <= count_reg + CW'(1);
			done      <= (count_reg == CW'(CYCLES - 1));
		end
	end

endmodule

// ---- core/frs_pkg.sv ----
package frs_pkg;

	// response chosen for a fault
	typedef enum logic [1:0] {
		FRS_RESP_FLAG,
		FRS_RESP_HICCUP,
		FRS_RESP_LATCH
	} frs_resp_t;

	// switching stop requests to the power stages
	typedef struct packed {
		logic flyback;
		logic channel;
	} frs_stop_t;

	// response controller states for the channel switching
	typedef enum logic [1:0] {
		FRS_RUN,
		FRS_HOLD,
		FRS_DELAY,
		FRS_LATCHED
	} frs_state_t;

endpackage

// ---- core/frs_regs.svh ----
`ifndef FRS_REGS_SVH
`define FRS_REGS_SVH

// register indexes; the byte address on the bus is four times the index
`define FRS_IDX_GLOBAL_CTRL   8'hB0
`define FRS_IDX_FLYBACK_CTRL  8'hB4
`define FRS_IDX_OC2_CTRL      8'hB6
`define FRS_IDX_CHAN_DISABLE  8'hBC
`define FRS_IDX_CURRENT_STS   8'hD5
`define FRS_IDX_FLYBACK_STS   8'hD8
`define FRS_IDX_CHAN_STS      8'hDA
`define FRS_IDX_IRQ_STATUS    8'hE0
`define FRS_IDX_IRQ_MASK      8'hE1

// field positions
`define FRS_BIT_INDIV_EN      7
`define FRS_BIT_SHORT_FLAG    7
`define FRS_POS_OC2_RESP      6
`define FRS_BIT_PHASE_FAULT   5
`define FRS_BIT_OC2_STS       1
`define FRS_BIT_SHORT_STS     4
`define FRS_IRQ_SHORT         0
`define FRS_IRQ_OC2           1
`define FRS_IRQ_PHASE         2

// reset values
`define FRS_RST_GLOBAL_CTRL   8'h00
`define FRS_RST_FLYBACK_CTRL  8'h00
`define FRS_RST_OC2_CTRL      8'h00
`define FRS_RST_CHAN_DISABLE  8'h00
`define FRS_RST_IRQ_MASK      8'h00

// timing
`define FRS_CLK_HZ            10000000
`define FRS_HICCUP_MS         500

`endif

// ---- core/frs_top.sv ----
// The APB interface to the registers is this design's own decision.
`include "frs_regs.svh"

// Behaviour
// - individual enable 0 takes responses from mode pins; 1 uses control bits.
// - short with control bit 0 flags, alerts, fails system, stops everything.
// - short with control bit 1 flags and alerts only, system fail released.
// - overcurrent-2 code 00 flags and alerts, switching continues.
// - every overcurrent-2 event records the detecting channels in a status field.
// - code 01 stops channels, restarts 500 ms after the condition clears.
// - code 10 stops channels and keeps them stopped after clearing.
// - code 11 behaves as code 00, flag only.
// - overcurrent-2 control register is one byte, read/write, resets to 00.
// - phase-removal bit 0 means disabling channels never raises a fault.
// - bit 1 and disabled channels over half of configured_phases triggers hiccup or latch-off.
module frs_top
	import frs_pkg::*;
#(
	parameter int unsigned CHANNELS      = 4,
	parameter int unsigned HICCUP_CYCLES =
		int'((64'd`FRS_HICCUP_MS * 64'd`FRS_CLK_HZ) / 64'd1000)
) (
	input  wire logic                clk,
	input  wire logic                rst,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// device side
	input  wire logic                device_enable,
	input  wire logic                channel_enable,
	input  wire logic [1:0]          mode_pin_resp,
	input  wire logic [2:0]          configured_phases,
	input  wire logic                fet_short_detect,
	input  wire logic [CHANNELS-1:0] second_level_overcurrent,
	output logic                     status_alert_n,
	output logic                     system_fail_n,
	output frs_stop_t                stop_req,
	output logic                     irq
);

	// maps a two-bit response code; code 11 falls back to flagging only
	function automatic frs_resp_t decode_resp(input logic [1:0] code);
		unique case (code)
			2'h1:    decode_resp = FRS_RESP_HICCUP;
			2'h2:    decode_resp = FRS_RESP_LATCH;
			default: decode_resp = FRS_RESP_FLAG;
		endcase
	endfunction

	// counts set bits of a channel vector
	function automatic logic [3:0] count_ones(input logic [CHANNELS-1:0] v);
		count_ones = 4'h0;
		for (int i = 0; i < CHANNELS; i++) begin
			count_ones = count_ones + {3'h0, v[i]};
		end
	endfunction

	logic [7:0]          global_ctrl_reg;
	logic [7:0]          flyback_ctrl_reg;
	logic [7:0]          oc2_ctrl_reg;
	logic [CHANNELS-1:0] chan_disable_reg;
	logic                short_sts_reg;
	logic                oc2_sts_reg;
	logic [CHANNELS-1:0] chan_sts_reg;
	logic [2:0]          irq_status_reg;
	logic [2:0]          irq_mask_reg;
	logic                short_latch_reg;
	logic                short_seen_reg;
	frs_state_t          state_reg;
	frs_state_t          state_next;

	logic       wr_done;
	logic       rd_start;
	logic [7:0] acc_idx;
	logic       acc_aligned;
	logic       indiv_en;
	logic       short_fails;
	frs_resp_t  oc2_resp;
	logic       oc2_any;
	logic       phase_fault;
	logic       current_fault;
	logic       short_event;
	logic       hiccup_done;
	logic       chan_recover;
	logic [2:0] irq_hit;

	// bus decode: one wait state, the write lands on the completing edge
	assign acc_idx     = paddr[9:2];
	assign acc_aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign rd_start    = psel && penable && !pready;
	assign wr_done     = psel && penable && pready && pwrite && !pslverr;

	// response selection
	assign indiv_en    = global_ctrl_reg[`FRS_BIT_INDIV_EN];
	assign short_fails = indiv_en ? !flyback_ctrl_reg[`FRS_BIT_SHORT_FLAG]
	                              : (decode_resp(mode_pin_resp) != FRS_RESP_FLAG);
	assign oc2_resp    = indiv_en ? decode_resp(oc2_ctrl_reg[`FRS_POS_OC2_RESP +: 2])
	                              : decode_resp(mode_pin_resp);

	// fault conditions; removed channels fault only when the option bit is on
	assign oc2_any     = |second_level_overcurrent;
	assign phase_fault = oc2_ctrl_reg[`FRS_BIT_PHASE_FAULT]
		&& ({count_ones(chan_disable_reg), 1'b0} > {1'b0, 1'b0, configured_phases});
	assign current_fault = oc2_any || phase_fault;
	assign short_event   = fet_short_detect && device_enable;

	// a latch-off ends when either enable input goes low
	assign chan_recover = !channel_enable || !device_enable;

	// events that raise interrupt status bits; first cycle of each fault only
	assign irq_hit[`FRS_IRQ_SHORT] = short_event && !short_seen_reg;
	assign irq_hit[`FRS_IRQ_OC2]   = oc2_any && !oc2_sts_reg;
	assign irq_hit[`FRS_IRQ_PHASE] = phase_fault && state_reg == FRS_RUN
		&& oc2_resp != FRS_RESP_FLAG;

	// control registers
	always_ff @(posedge clk) begin
		if (rst) begin
			global_ctrl_reg  <= `FRS_RST_GLOBAL_CTRL;
			flyback_ctrl_reg <= `FRS_RST_FLYBACK_CTRL;
			oc2_ctrl_reg     <= `FRS_RST_OC2_CTRL;
			chan_disable_reg <= CHANNELS'(`FRS_RST_CHAN_DISABLE);
			irq_mask_reg     <= 3'(`FRS_RST_IRQ_MASK);
		end else if (wr_done) begin
			unique case (acc_idx)
				`FRS_IDX_GLOBAL_CTRL:  global_ctrl_reg  <= pwdata[7:0];
				`FRS_IDX_FLYBACK_CTRL: flyback_ctrl_reg <= pwdata[7:0];
				`FRS_IDX_OC2_CTRL:     oc2_ctrl_reg     <= pwdata[7:0];
				`FRS_IDX_CHAN_DISABLE: chan_disable_reg <= pwdata[CHANNELS-1:0];
				`FRS_IDX_IRQ_MASK:     irq_mask_reg     <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// sticky fault status; set wins over a write-one clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			short_sts_reg <= 1'b0;
			oc2_sts_reg   <= 1'b0;
			chan_sts_reg  <= '0;
		end else begin
			if (short_event) begin
				short_sts_reg <= 1'b1;
			end else if (wr_done && acc_idx == `FRS_IDX_FLYBACK_STS
			             && pwdata[`FRS_BIT_SHORT_STS]) begin
				short_sts_reg <= 1'b0;
			end
			if (oc2_any) begin
				oc2_sts_reg <= 1'b1;
			end else if (wr_done && acc_idx == `FRS_IDX_CURRENT_STS
			             && pwdata[`FRS_BIT_OC2_STS]) begin
				oc2_sts_reg <= 1'b0;
			end
			for (int i = 0; i < CHANNELS; i++) begin
				if (second_level_overcurrent[i]) begin
					chan_sts_reg[i] <= 1'b1;
				end else if (wr_done && acc_idx == `FRS_IDX_CHAN_STS && pwdata[i]) begin
					chan_sts_reg[i] <= 1'b0;
				end
			end
		end
	end

	// interrupt status: raised as a fault starts; overcurrent only with its status clear, phase only in FRS_RUN with a stopping response
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_status_reg <= 3'h0;
		end else begin
			// set wins over the write-one clear, as for the fault status
			for (int i = 0; i < 3; i++) begin
				if (irq_hit[i]) begin
					irq_status_reg[i] <= 1'b1;
				end else if (wr_done && acc_idx == `FRS_IDX_IRQ_STATUS && pwdata[i]) begin
					irq_status_reg[i] <= 1'b0;
				end
			end
		end
	end

	// short shutdown latch: only the device enable going low releases it
	always_ff @(posedge clk) begin
		if (rst) begin
			short_latch_reg <= 1'b0;
			short_seen_reg  <= 1'b0;
		end else if (!device_enable) begin
			short_latch_reg <= 1'b0;
			short_seen_reg  <= 1'b0;
		end else begin
			short_seen_reg <= fet_short_detect;
			if (fet_short_detect && short_fails) begin
				short_latch_reg <= 1'b1;
			end
		end
	end

	// channel response sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			FRS_RUN: begin
				if (current_fault && oc2_resp == FRS_RESP_HICCUP) begin
					state_next = FRS_HOLD;
				end else if (current_fault && oc2_resp == FRS_RESP_LATCH) begin
					state_next = FRS_LATCHED;
				end
			end
			FRS_HOLD: begin
				if (!current_fault) begin
					state_next = FRS_DELAY;
				end
			end
			FRS_DELAY: begin
				if (current_fault) begin
					state_next = FRS_HOLD;
				end else if (hiccup_done) begin
					state_next = FRS_RUN;
				end
			end
			FRS_LATCHED: begin
				if (chan_recover) begin
					state_next = FRS_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= FRS_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// restart wait runs only while the fault is absent
	frs_hiccup_timer #(
		.CYCLES (HICCUP_CYCLES)
	) u_hiccup (
		.clk  (clk),
		.rst  (rst),
		.run  (state_reg == FRS_DELAY && !current_fault),
		.done (hiccup_done)
	);

	// pins and stop requests, all registered
	always_ff @(posedge clk) begin
		if (rst) begin
			status_alert_n   <= 1'b1;
			system_fail_n    <= 1'b1;
			stop_req         <= '0;
			irq              <= 1'b0;
		end else begin
			status_alert_n   <= !(short_sts_reg || oc2_sts_reg);
			system_fail_n    <= !short_latch_reg;
			stop_req.flyback <= short_latch_reg;
			stop_req.channel <= short_latch_reg || state_next != FRS_RUN;
			irq              <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// apb answer: data and pready one cycle into the access phase
	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (rd_start) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (!acc_aligned) begin
				pslverr <= 1'b1;
			end else begin
				unique case (acc_idx)
					`FRS_IDX_GLOBAL_CTRL:  prdata[7:0] <= global_ctrl_reg;
					`FRS_IDX_FLYBACK_CTRL: prdata[7:0] <= flyback_ctrl_reg;
					`FRS_IDX_OC2_CTRL:     prdata[7:0] <= oc2_ctrl_reg;
					`FRS_IDX_CHAN_DISABLE: prdata[CHANNELS-1:0] <= chan_disable_reg;
					`FRS_IDX_CURRENT_STS:  prdata[`FRS_BIT_OC2_STS] <= oc2_sts_reg;
					`FRS_IDX_FLYBACK_STS:  prdata[`FRS_BIT_SHORT_STS] <= short_sts_reg;
					`FRS_IDX_CHAN_STS:     prdata[CHANNELS-1:0] <= chan_sts_reg;
					`FRS_IDX_IRQ_STATUS:   prdata[2:0] <= irq_status_reg;
					`FRS_IDX_IRQ_MASK:     prdata[2:0] <= irq_mask_reg;
					default:               pslverr <= 1'b1;
				endcase
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

// ---- dv/frs_apb_host.sv ----
// management-bus host: the system controller's side of the register bus
module frs_apb_host (
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ns;

	// bus idle from time zero
	initial {psel, penable, pwrite, paddr, pwdata} = '0;

	// holds the request until pready is seen; waits as long as the slave needs
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'h1;
		// pready and the answer are taken at the rising edge, before the slave's flops move
		do @(posedge clk); while (pready !== 1'h1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		pwdata  <= ~wd; // stale data must not look valid once released
	endtask
endmodule

// ---- dv/frs_top_sva.sv ----
module frs_top_sva
	import frs_pkg::*;
#(
	parameter int unsigned CHANNELS      = 4,
	parameter int unsigned HICCUP_CYCLES = 20
) (
	input wire logic                clk,
	input wire logic                rst,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic [31:0]         prdata,
	input wire logic                device_enable,
	input wire logic                channel_enable,
	input wire logic                fet_short_detect,
	input wire logic [CHANNELS-1:0] second_level_overcurrent,
	input wire logic                status_alert_n,
	input wire logic                system_fail_n,
	input wire frs_stop_t           stop_req
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	// quiet cycles with both enables up; an automatic restart never comes sooner
	logic [31:0] quiet_reg;
	always_ff @(posedge clk) begin
		if (rst || (|second_level_overcurrent) || !device_enable || !channel_enable) begin
			quiet_reg <= 32'h0;
		end else begin
			quiet_reg <= quiet_reg + 32'h1;
		end
	end

	sequence short_seen;
		device_enable && fet_short_detect;
	endsequence
	sequence fail_begins;
		$fell(system_fail_n);
	endsequence

	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	err_no_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer malformed");
	short_alert_a: assert property (short_seen |-> ##[1:4] !status_alert_n)
		else $error("short not flagged");
	oc2_alert_a: assert property ((|second_level_overcurrent) |-> ##[1:4] !status_alert_n)
		else $error("overcurrent not flagged");
	fail_cause_a: assert property (fail_begins |-> $past(fet_short_detect, 2)
		|| $past(fet_short_detect, 3) || $past(fet_short_detect))
		else $error("system fail without short");
	fail_stop_a: assert property (!system_fail_n |-> stop_req.flyback)
		else $error("flyback runs in system fail");
	en_release_a: assert property (!device_enable [*3] |-> system_fail_n)
		else $error("enable low did not clear fail");
	hiccup_wait_a: assert property ($fell(stop_req.channel) && device_enable && channel_enable
		|-> quiet_reg >= HICCUP_CYCLES)
		else $error("restart before delay");
endmodule

bind frs_top frs_top_sva #(.CHANNELS(CHANNELS), .HICCUP_CYCLES(HICCUP_CYCLES)) u_frs_top_sva (
	.clk(clk), .rst(rst), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.device_enable(device_enable), .channel_enable(channel_enable),
	.fet_short_detect(fet_short_detect), .second_level_overcurrent(second_level_overcurrent),
	.status_alert_n(status_alert_n), .system_fail_n(system_fail_n), .stop_req(stop_req)
);

// ---- dv/tb_fault_response_selector.sv ----
`include "frs_regs.svh"

module tb_fault_response_selector;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned HC = 20;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic device_enable, channel_enable, fet_short_detect, status_alert_n, system_fail_n, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] mode_pin_resp;
	logic [2:0] configured_phases;
	logic [3:0] oc2;
	frs_pkg::frs_stop_t stop_req;
	int n_fail, num_checks;

	frs_top #(.HICCUP_CYCLES(HC)) u_frs_top (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .device_enable(device_enable),
		.channel_enable(channel_enable), .mode_pin_resp(mode_pin_resp),
		.configured_phases(configured_phases), .fet_short_detect(fet_short_detect),
		.second_level_overcurrent(oc2), .status_alert_n(status_alert_n),
		.system_fail_n(system_fail_n), .stop_req(stop_req), .irq(irq));
	frs_apb_host u_frs_apb_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// shared helpers: compare, bus access, settle
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		u_frs_apb_host.xfer(1'h1, idx, d, rd, err);
	endtask
	task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
		u_frs_apb_host.xfer(1'h0, idx, 32'h0, rd, err);
		chk(what, exp, rd);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic clr_all;
		wr(`FRS_IDX_CURRENT_STS, 32'h2);
		wr(`FRS_IDX_FLYBACK_STS, 32'h10);
		wr(`FRS_IDX_CHAN_STS, 32'hF);
		wr(`FRS_IDX_IRQ_STATUS, 32'h7);
		cyc(2);
		chk("alert idle", 32'h1, 32'(status_alert_n));
	endtask
	task automatic ch_toggle;
		@(posedge clk) channel_enable <= 1'h0;
		cyc(3);
		@(posedge clk) channel_enable <= 1'h1;
		cyc(2);
		chk("channel resumed", 32'h0, 32'(stop_req.channel));
	endtask

	task automatic t_regs;
		rdchk("oc2 ctrl reset", `FRS_IDX_OC2_CTRL, 32'h0);
		wr(`FRS_IDX_OC2_CTRL, 32'h1E5);
		rdchk("oc2 ctrl byte", `FRS_IDX_OC2_CTRL, 32'hE5);
		wr(`FRS_IDX_OC2_CTRL, 32'h0);
		u_frs_apb_host.xfer(1'h0, 8'h01, 32'h0, rd, err);
		chk("unmapped", 32'h1, 32'(err));
	endtask

	task automatic t_short(input logic [31:0] glob, input logic [31:0] fly,
			input logic [1:0] mode, input logic fail);
		wr(`FRS_IDX_GLOBAL_CTRL, glob);
		wr(`FRS_IDX_FLYBACK_CTRL, fly);
		@(posedge clk) mode_pin_resp <= mode;
		@(posedge clk) fet_short_detect <= 1'h1;
		cyc(4);
		chk("short alert", 32'h0, 32'(status_alert_n));
		chk("system fail", 32'(!fail), 32'(system_fail_n));
		chk("stop all", 32'({fail, fail}), 32'(stop_req));
		rdchk("short sts", `FRS_IDX_FLYBACK_STS, 32'h10);
		@(posedge clk) fet_short_detect <= 1'h0;
		@(posedge clk) device_enable <= 1'h0;
		cyc(3);
		@(posedge clk) device_enable <= 1'h1;
		clr_all;
		chk("fail released", 32'h1, 32'(system_fail_n));
	endtask

	task automatic t_oc2(input logic [1:0] code);
		wr(`FRS_IDX_GLOBAL_CTRL, 32'h80);
		wr(`FRS_IDX_OC2_CTRL, {24'h0, code, 6'h0});
		@(posedge clk) oc2 <= 4'h4;
		cyc(3);
		chk("oc2 alert", 32'h0, 32'(status_alert_n));
		chk("oc2 stop", 32'(code == 2'h1 || code == 2'h2), 32'(stop_req));
		@(posedge clk) oc2 <= 4'h0;
		rdchk("oc2 sts", `FRS_IDX_CURRENT_STS, 32'h2);
		rdchk("oc2 channel", `FRS_IDX_CHAN_STS, 32'h4);
		cyc(HC + 10);
		chk("oc2 later", 32'(code == 2'h2), 32'(stop_req.channel));
		ch_toggle;
		clr_all;
	endtask

	task automatic t_retrig;
		wr(`FRS_IDX_OC2_CTRL, 32'h40);
		repeat (2) begin
			@(posedge clk) oc2 <= 4'h1;
			@(posedge clk) oc2 <= 4'h0;
			cyc(HC - 5);
		end
		chk("delay restarted", 32'h1, 32'(stop_req.channel));
		cyc(12);
		chk("auto restart", 32'h0, 32'(stop_req.channel));
		chk("irq masked", 32'h0, 32'(irq));
		wr(`FRS_IDX_IRQ_MASK, 32'h2);
		cyc(2);
		chk("irq raised", 32'h1, 32'(irq));
		wr(`FRS_IDX_IRQ_STATUS, 32'h2);
		cyc(2);
		chk("irq cleared", 32'h0, 32'(irq));
		clr_all;
	endtask

	task automatic t_phase;
		wr(`FRS_IDX_OC2_CTRL, 32'h80);
		wr(`FRS_IDX_CHAN_DISABLE, 32'h7);
		cyc(3);
		chk("phase off", 32'h0, 32'(stop_req.channel));
		wr(`FRS_IDX_CHAN_DISABLE, 32'h3);
		wr(`FRS_IDX_OC2_CTRL, 32'hA0);
		cyc(3);
		chk("half disabled", 32'h0, 32'(stop_req.channel));
		wr(`FRS_IDX_CHAN_DISABLE, 32'h7);
		cyc(3);
		chk("phase latch", 32'h1, 32'(stop_req.channel));
		wr(`FRS_IDX_CHAN_DISABLE, 32'h0);
		ch_toggle;
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// clock at 10 MHz
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// a hang counts as a failure and ends the run in the same place
	initial begin
		repeat (6000) @(posedge clk);
		n_fail++;
		final_report;
	end

	// main sequence
	initial begin
		{rst, device_enable, channel_enable} = 3'h7;
		{fet_short_detect, oc2, mode_pin_resp} = '0;
		configured_phases = 3'h4;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		t_regs;
		t_short(32'h80, 32'h00, 2'h0, 1'h1);
		t_short(32'h80, 32'h80, 2'h2, 1'h0);
		t_short(32'h00, 32'h00, 2'h0, 1'h0);
		t_short(32'h00, 32'h80, 2'h2, 1'h1);
		for (int c = 0; c < 4; c++) t_oc2(2'(c));
		t_retrig;
		t_phase;
		final_report;
	end
endmodule
